// ==== logic/dcd_pkg.sv ====
// Constants for the command decoder of a dual asynchronous receiver/transmitter.
// Assumes a 4-bit register address bus and an 8-bit data bus from the host.
package dcd_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CHAN_A_CMD = 4'h2;
    localparam logic [3:0] ADDR_CHAN_B_CMD = 4'hA;
    localparam logic [3:0] ADDR_START_SET = 4'hE;
    localparam logic [3:0] ADDR_STOP_CLR = 4'hF;

    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int CMD_HI_LSB = 4;
    localparam int CMD_TX_LSB = 2;
    localparam int CMD_RX_LSB = 0;
    localparam logic [1:0] EN_CODE_ENABLE = 2'h1;
    localparam logic [1:0] EN_CODE_DISABLE = 2'h2;

    // Upper-nibble command codes
    localparam logic [3:0] CMD_RX_EXT_SET = 4'h8;
    localparam logic [3:0] CMD_RX_EXT_CLR = 4'h9;
    localparam logic [3:0] CMD_TX_EXT_SET = 4'hA;
    localparam logic [3:0] CMD_TX_EXT_CLR = 4'hB;
    localparam logic [3:0] CMD_GROUP_C = 4'hC;
    localparam logic [3:0] CMD_GROUP_D = 4'hD;
    localparam logic [3:0] CMD_RSVD_E = 4'hE;
    localparam logic [3:0] CMD_RSVD_F = 4'hF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_EXT_BIT = 1'b0;
    localparam logic RST_CHAN_EN = 1'b0;
    localparam logic [7:0] RST_OUTPUT_PORT = 8'h00;

endpackage : dcd_pkg

// ==== logic/dcd_bus_if.sv ====
// Carries one synchronised host access from the top to the decoders.
// Assumes strobes are single-cycle pulses on the core clock.
`timescale 1ns/1ps
interface dcd_bus_if;
    import dcd_pkg::*;
    logic wr_stb;
    logic rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;

    modport src (output wr_stb, output rd_stb, output addr, output data);
    modport dst (input wr_stb, input rd_stb, input addr, input data);
endinterface : dcd_bus_if

// ==== logic/dcd_chan_decode.sv ====
// One channel's command register decoder: extend bits, enables, group C/D pulses.
// Assumes a synchronised access on the bus interface; one instance per channel.
`timescale 1ns/1ps
module dcd_chan_decode
    import dcd_pkg::*;
#(
    parameter logic [3:0] CMD_ADDR = 4'h2
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    dcd_bus_if.dst bus,
    output logic rx_ext_o,
    output logic tx_ext_o,
    output logic rx_en_o,
    output logic tx_en_o,
    output logic cmd_c_o,
    output logic cmd_d_o
);

    logic hit;
    logic [3:0] hi;
    logic [1:0] tx_code;
    logic [1:0] rx_code;

    assign hit = bus.wr_stb && (bus.addr == CMD_ADDR);
    assign hi = bus.data[CMD_HI_LSB +: 4];
    assign tx_code = bus.data[CMD_TX_LSB +: 2];
    assign rx_code = bus.data[CMD_RX_LSB +: 2];

    // ------------------------------------------------------------
    // Extend bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_ext_o <= RST_EXT_BIT;
            tx_ext_o <= RST_EXT_BIT;
        end
        else if (hit)
        begin
            case (hi)
                CMD_RX_EXT_SET: rx_ext_o <= 1'b1;
                CMD_RX_EXT_CLR: rx_ext_o <= 1'b0;
                CMD_TX_EXT_SET: tx_ext_o <= 1'b1;
                CMD_TX_EXT_CLR: tx_ext_o <= 1'b0;
                default: ; // Reserved codes do nothing
            endcase
        end
    end

    // ------------------------------------------------------------
    // Enables, independent of the upper nibble
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_en_o <= RST_CHAN_EN;
            tx_en_o <= RST_CHAN_EN;
        end
        else if (hit)
        begin
            if (rx_code == EN_CODE_ENABLE) rx_en_o <= 1'b1;
            else if (rx_code == EN_CODE_DISABLE) rx_en_o <= 1'b0;
            if (tx_code == EN_CODE_ENABLE) tx_en_o <= 1'b1;
            else if (tx_code == EN_CODE_DISABLE) tx_en_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Chip-level command pulses; meaning depends on channel
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_c_o <= 1'b0;
            cmd_d_o <= 1'b0;
        end
        else
        begin
            cmd_c_o <= hit && (hi == CMD_GROUP_C);
            cmd_d_o <= hit && (hi == CMD_GROUP_D);
        end
    end

endmodule : dcd_chan_decode

// ==== logic/dcd_addr_cmd.sv ====
// Address-triggered commands: counter start/stop and output port set/clear.
// Assumes a synchronised access on the bus interface.
`timescale 1ns/1ps
module dcd_addr_cmd
    import dcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    dcd_bus_if.dst bus,
    output logic ct_start_o,
    output logic ct_stop_o,
    output logic [DATA_W-1:0] out_port_reg_o,
    output logic [DATA_W-1:0] out_pins_o
);

    logic set_hit;
    logic clr_hit;
    logic [DATA_W-1:0] port_nxt;

    assign set_hit = bus.wr_stb && (bus.addr == ADDR_START_SET);
    assign clr_hit = bus.wr_stb && (bus.addr == ADDR_STOP_CLR);

    always_comb
    begin
        port_nxt = out_port_reg_o;
        if (set_hit) port_nxt = out_port_reg_o | bus.data;
        if (clr_hit) port_nxt = out_port_reg_o & ~bus.data;
    end

    // ------------------------------------------------------------
    // Output port register and inverted pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_port_reg_o <= RST_OUTPUT_PORT;
            out_pins_o <= ~RST_OUTPUT_PORT;
        end
        else
        begin
            out_port_reg_o <= port_nxt;
            out_pins_o <= ~port_nxt; // Pins show complement
        end
    end

    // ------------------------------------------------------------
    // Counter/timer pulses, taken on a read of the address only
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ct_start_o <= 1'b0;
            ct_stop_o <= 1'b0;
        end
        else
        begin
            ct_start_o <= bus.rd_stb && (bus.addr == ADDR_START_SET);
            ct_stop_o <= bus.rd_stb && (bus.addr == ADDR_STOP_CLR);
        end
    end

endmodule : dcd_addr_cmd

// ==== logic/dcd_top.sv ====
// Top of the command decoder: pin synchronisers, chip-level mode state.
// Assumes an asynchronous host bus with active-low strobes and one 10 MHz clock.
//
// How it works
// - Receiver extend-set command sets that channel's receiver extend bit.
// - Receiver extend-clear command clears that channel's receiver extend bit.
// - Transmitter extend-set command sets that channel's transmitter extend bit.
// - Transmitter extend-clear command clears that channel's transmitter extend bit.
// - Code 1100 to channel A enters chip-wide standby.
// - Standby ends on hardware reset or set-active command.
// - Code 1101 to channel A leaves standby.
// - Code 1100 to channel B in chain mode resets in-service latch.
// - Code 1101 to channel B enters daisy-chain vectored mode.
// - Four address commands: start, stop counter; set, clear output bits.
// - Counter commands run on a read of their address, output-bit commands on a write.
// - Lower nibble enables or disables transmitter and receiver independently.
// - Read of address 0E starts counter, drives no data.
// - Write to 0E sets output bits given as ones; pins inverted.
`timescale 1ns/1ps
module dcd_top
    import dcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic int_ack_i,
    output logic rx_ext_a_o,
    output logic tx_ext_a_o,
    output logic rx_ext_b_o,
    output logic tx_ext_b_o,
    output logic rx_en_a_o,
    output logic tx_en_a_o,
    output logic rx_en_b_o,
    output logic tx_en_b_o,
    output logic standby_o,
    output logic chain_mode_o,
    output logic in_service_latch_o,
    output logic chain_enable_out_o,
    output logic ct_start_o,
    output logic ct_stop_o,
    output logic [DATA_W-1:0] output_port_reg_o,
    output logic [DATA_W-1:0] out_pins_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i) rst_sync_r <= 2'b00;
        else rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 3 + ADDR_W + DATA_W + 1;
    logic [SYNC_W-1:0] pin_meta_r;
    logic [SYNC_W-1:0] pin_sync_r;
    logic rd_act;
    logic wr_act;
    logic rd_act_r;
    logic wr_act_r;
    logic ack_sync;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= {3'b111, {(ADDR_W + DATA_W + 1){1'b0}}};
            pin_sync_r <= {3'b111, {(ADDR_W + DATA_W + 1){1'b0}}};
        end
        else
        begin
            pin_meta_r <= {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i, int_ack_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Access is taken once, at the leading edge of the strobe
    assign rd_act = !pin_sync_r[SYNC_W-1] && !pin_sync_r[SYNC_W-2];
    assign wr_act = !pin_sync_r[SYNC_W-1] && !pin_sync_r[SYNC_W-3];
    assign ack_sync = pin_sync_r[0];

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
        end
        else
        begin
            rd_act_r <= rd_act;
            wr_act_r <= wr_act;
        end
    end

    // ------------------------------------------------------------
    // Internal access carrier
    // ------------------------------------------------------------
    dcd_bus_if bus ();

    // Data must be stable by the strobe edge; it is sampled together with the strobe
    assign bus.rd_stb = rd_act && !rd_act_r;
    assign bus.wr_stb = wr_act && !wr_act_r;
    assign bus.addr = pin_sync_r[DATA_W+1 +: ADDR_W];
    assign bus.data = pin_sync_r[1 +: DATA_W];

    // ------------------------------------------------------------
    // Channel decoders
    // ------------------------------------------------------------
    logic cmd_c_a;
    logic cmd_d_a;
    logic cmd_c_b;
    logic cmd_d_b;

    dcd_chan_decode #(.CMD_ADDR(ADDR_CHAN_A_CMD)) u_chan_a (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .bus(bus),
        .rx_ext_o(rx_ext_a_o),
        .tx_ext_o(tx_ext_a_o),
        .rx_en_o(rx_en_a_o),
        .tx_en_o(tx_en_a_o),
        .cmd_c_o(cmd_c_a),
        .cmd_d_o(cmd_d_a)
    );

    dcd_chan_decode #(.CMD_ADDR(ADDR_CHAN_B_CMD)) u_chan_b (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .bus(bus),
        .rx_ext_o(rx_ext_b_o),
        .tx_ext_o(tx_ext_b_o),
        .rx_en_o(rx_en_b_o),
        .tx_en_o(tx_en_b_o),
        .cmd_c_o(cmd_c_b),
        .cmd_d_o(cmd_d_b)
    );

    // ------------------------------------------------------------
    // Address-triggered commands
    // ------------------------------------------------------------
    dcd_addr_cmd u_addr_cmd (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .bus(bus),
        .ct_start_o(ct_start_o),
        .ct_stop_o(ct_stop_o),
        .out_port_reg_o(output_port_reg_o),
        .out_pins_o(out_pins_o)
    );

    // ------------------------------------------------------------
    // Standby, chip wide
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n) standby_o <= 1'b0; // Hardware reset wakes
        else if (cmd_c_a) standby_o <= 1'b1;
        else if (cmd_d_a) standby_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Daisy-chain mode and in-service latch
    // ------------------------------------------------------------
    // No command leaves chain mode; only reset does
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n) chain_mode_o <= 1'b0;
        else if (cmd_d_b) chain_mode_o <= 1'b1;
    end

    // Acknowledge wins over a same-cycle reset command
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_service_latch_o <= 1'b0;
            chain_enable_out_o <= 1'b1;
        end
        else if (chain_mode_o && ack_sync)
        begin
            in_service_latch_o <= 1'b1;
            chain_enable_out_o <= 1'b0;
        end
        else if (chain_mode_o && cmd_c_b)
        begin
            in_service_latch_o <= 1'b0;
            chain_enable_out_o <= 1'b1;
        end
    end

endmodule : dcd_top

// ==== sim/dcd_host_model.sv ====
// Host processor model driving the decoder's parallel bus pins.
// Assumes one core clock; accesses are issued one at a time by the bench.
`timescale 1ns/1ps
module dcd_host_model
    import dcd_pkg::*;
(
    input wire logic clk_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o
);
    initial
    begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 4'h0;
        data_o = 8'h00;
    end
    // ------------------------------------------------------------
    // One access; held long enough for the two-flop synchronisers
    // ------------------------------------------------------------
    task automatic access(input logic [3:0] a, input logic [7:0] d, input logic rd);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= !rd;
        wr_n_o <= rd;
        addr_o <= a;
        data_o <= d;
        repeat (5) @(posedge clk_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        // Released lines show junk, not the last value
        addr_o <= ~a;
        data_o <= ~d;
        repeat (4) @(posedge clk_i);
    endtask : access
endmodule : dcd_host_model

// ==== sim/dcd_top_asserts.sv ====
// Checker on the decoder's top ports.
// Assumes strobes held low at least five clocks, as the host model does.
`timescale 1ns/1ps
module dcd_top_asserts
    import dcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic rx_ext_a_o,
    input wire logic standby_o,
    input wire logic chain_mode_o,
    input wire logic in_service_latch_o,
    input wire logic chain_enable_out_o,
    input wire logic ct_start_o,
    input wire logic ct_stop_o,
    input wire logic [DATA_W-1:0] output_port_reg_o,
    input wire logic [DATA_W-1:0] out_pins_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire wr_a = !cs_n_i && !wr_n_i && addr_i == ADDR_CHAN_A_CMD;
    wire wr_b = !cs_n_i && !wr_n_i && addr_i == ADDR_CHAN_B_CMD;
    wire rd_any = !cs_n_i && !rd_n_i;
    wire [3:0] hi = data_i[7:4];
    // ------------------------------------------------------------
    // Effects tied to their pin cause, three clocks back
    // ------------------------------------------------------------
    chk_rx_ext_set: assert property (
        $rose(rx_ext_a_o) |-> $past(wr_a && hi == CMD_RX_EXT_SET, 3))
        else $error("rx extend rose without set");
    chk_rx_ext_clr: assert property (
        $fell(rx_ext_a_o) |-> $past(wr_a && hi == CMD_RX_EXT_CLR, 3))
        else $error("rx extend fell without clear");
    chk_standby_on: assert property (
        $rose(standby_o) |-> $past(wr_a && hi == CMD_GROUP_C, 3))
        else $error("standby without command");
    chk_standby_off: assert property (
        $fell(standby_o) |-> $past(wr_a && hi == CMD_GROUP_D, 3))
        else $error("standby left without command");
    chk_chain_on: assert property (
        $rose(chain_mode_o) |-> $past(wr_b && hi == CMD_GROUP_D, 3))
        else $error("chain mode without command");
    chk_start_cause: assert property (
        $rose(ct_start_o) |-> $past(rd_any && addr_i == ADDR_START_SET, 3))
        else $error("start without read");
    chk_stop_cause: assert property (
        $rose(ct_stop_o) |-> $past(rd_any && addr_i == ADDR_STOP_CLR, 3))
        else $error("stop without read");
    chk_start_single: assert property (
        ct_start_o |=> !ct_start_o)
        else $error("start pulse repeated");
    chk_chain_enable: assert property (
        $changed(in_service_latch_o) |-> ##[0:1] chain_enable_out_o == !in_service_latch_o)
        else $error("chain enable not inverse of latch");
    chk_pins_inverse: assert property (
        $changed(output_port_reg_o) |-> ##[0:1] out_pins_o == ~output_port_reg_o)
        else $error("pins not inverse of port");
    cov_start: cover property (ct_start_o);
    cov_standby: cover property ($rose(standby_o));
    cov_latch: cover property ($fell(in_service_latch_o));
    cov_chain: cover property ($rose(chain_mode_o));
endmodule : dcd_top_asserts
bind dcd_top dcd_top_asserts u_dcd_top_asserts (.clk_i, .rst_n_i, .cs_n_i, .rd_n_i,
    .wr_n_i, .addr_i, .data_i, .rx_ext_a_o, .standby_o, .chain_mode_o,
    .in_service_latch_o, .chain_enable_out_o, .ct_start_o, .ct_stop_o,
    .output_port_reg_o, .out_pins_o);

// ==== sim/duart_command_decoder_tb_top.sv ====
// Self-checking bench: host model, decoder and a behavioural reference.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module duart_command_decoder_tb_top;
    import dcd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic int_ack_i = 1'b0;
    logic cs_n, rd_n, wr_n;
    logic ct_start, ct_stop;
    logic [3:0] addr;
    logic [7:0] data;
    logic [27:0] seen;
    logic [1:0] m_rx, m_tx, m_rxe, m_txe;
    logic m_sb, m_ch, m_lat;
    logic [7:0] m_port;
    int m_start, m_stop, start_cnt, stop_cnt, error_cnt, checked;
    logic [3:0] addrs [3] = '{ADDR_START_SET, ADDR_STOP_CLR, 4'h5};
    always #50 clk_i = ~clk_i;
    dcd_host_model u_dcd_host_model (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .addr_o(addr), .data_o(data));
    dcd_top u_dcd_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .addr_i(addr), .data_i(data), .int_ack_i(int_ack_i),
        .rx_ext_a_o(seen[27]), .tx_ext_a_o(seen[26]), .rx_ext_b_o(seen[25]),
        .tx_ext_b_o(seen[24]), .rx_en_a_o(seen[23]), .tx_en_a_o(seen[22]),
        .rx_en_b_o(seen[21]), .tx_en_b_o(seen[20]), .standby_o(seen[19]),
        .chain_mode_o(seen[18]), .in_service_latch_o(seen[17]),
        .chain_enable_out_o(seen[16]), .ct_start_o(ct_start), .ct_stop_o(ct_stop),
        .output_port_reg_o(seen[15:8]), .out_pins_o(seen[7:0]));
    // Pulses last one cycle, so count them as they pass
    always @(posedge clk_i)
    begin
        if (ct_start === 1'b1) start_cnt++;
        if (ct_stop === 1'b1) stop_cnt++;
    end
    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    task automatic model_reset();
        {m_rx, m_tx, m_rxe, m_txe, m_sb, m_ch, m_lat} = '0;
        m_port = 8'h00;
    endtask : model_reset
    task automatic model_acc(input logic [3:0] a, input logic [7:0] d, input logic rd);
        int c;
        c = (a == ADDR_CHAN_B_CMD);
        if (rd)
        begin
            if (a == ADDR_START_SET) m_start++;
            if (a == ADDR_STOP_CLR) m_stop++;
        end
        else if (a == ADDR_START_SET) m_port |= d;
        else if (a == ADDR_STOP_CLR) m_port &= ~d;
        else if (a == ADDR_CHAN_A_CMD || a == ADDR_CHAN_B_CMD)
        begin
            case (d[7:4])
                4'h8: m_rx[c] = 1'b1;
                4'h9: m_rx[c] = 1'b0;
                4'hA: m_tx[c] = 1'b1;
                4'hB: m_tx[c] = 1'b0;
                4'hC: if (c == 0) m_sb = 1'b1; else if (m_ch) m_lat = 1'b0;
                4'hD: if (c == 0) m_sb = 1'b0; else m_ch = 1'b1;
                default: ;
            endcase
            if (d[1:0] == 2'h1) m_rxe[c] = 1'b1;
            if (d[1:0] == 2'h2) m_rxe[c] = 1'b0;
            if (d[3:2] == 2'h1) m_txe[c] = 1'b1;
            if (d[3:2] == 2'h2) m_txe[c] = 1'b0;
        end
    endtask : model_acc
    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [27:0] expv();
        return {m_rx[0], m_tx[0], m_rx[1], m_tx[1], m_rxe[0], m_txe[0], m_rxe[1],
            m_txe[1], m_sb, m_ch, m_lat, ~m_lat, m_port, ~m_port};
    endfunction : expv
    task automatic run(input logic [3:0] a, input logic [7:0] d, input logic rd);
        u_dcd_host_model.access(a, d, rd);
        model_acc(a, d, rd);
    endtask : run
    task automatic tally_and_finish();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #500_000;
        error_cnt++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        logic ack;
        logic [3:0] a;
        void'($urandom(16));
        model_reset();
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(seen, expv());
        // Every upper code on both channels, twice, with random acks between
        for (int j = 0; j < 64; j++)
        begin
            ack = $urandom;
            int_ack_i <= ack;
            repeat (3) @(posedge clk_i);
            int_ack_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            if (ack && m_ch) m_lat = 1'b1;
            a = j[4] ? ADDR_CHAN_B_CMD : ADDR_CHAN_A_CMD;
            run(a, {j[3:0], 4'($urandom)}, 1'b0);
            check(seen, expv());
        end
        // Acknowledge in chain mode, then the latch reset from channel B
        int_ack_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        int_ack_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        if (m_ch) m_lat = 1'b1;
        check(seen, expv());
        run(ADDR_CHAN_B_CMD, 8'hC0, 1'b0);
        check(seen, expv());
        // Each address command once, then random ones and an unmapped address
        run(ADDR_START_SET, 8'h00, 1'b1);
        run(ADDR_STOP_CLR, 8'h00, 1'b1);
        run(ADDR_START_SET, 8'hA5, 1'b0);
        check(seen, expv());
        run(ADDR_STOP_CLR, 8'h81, 1'b0);
        check(seen, expv());
        for (int j = 0; j < 16; j++)
        begin
            run(addrs[$urandom % 3], 8'($urandom), 1'($urandom));
            check(seen, expv());
        end
        check(28'(start_cnt), 28'(m_start));
        check(28'(stop_cnt), 28'(m_stop));
        // Standby then a hardware reset in mid-run
        run(ADDR_CHAN_A_CMD, 8'hC0, 1'b0);
        check(seen, expv());
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        model_reset();
        repeat (6) @(posedge clk_i);
        check(seen, expv());
        tally_and_finish();
    end
endmodule : duart_command_decoder_tb_top
